// File: inc/ogf_pkg.sv
// constants for the output gain and format block
package ogf_pkg;
    localparam int SAMP_W = 16;
    localparam int MANT_W = 8;
    localparam int EXP_W  = 4;
    localparam int DEC_W  = 3;
    localparam int ADDR_W = 12;
    localparam int FULL_W = 48;
    localparam int FRAC_W = 8;
    localparam int IDX_MANT = 6;
    localparam int IDX_EXP  = 7;
    localparam int IDX_FMT  = 8;
    localparam logic [ADDR_W-1:0] ADDR_MANT = ADDR_W'(4 * IDX_MANT);
    localparam logic [ADDR_W-1:0] ADDR_EXP  = ADDR_W'(4 * IDX_EXP);
    localparam logic [ADDR_W-1:0] ADDR_FMT  = ADDR_W'(4 * IDX_FMT);
    localparam int EXP_SYNC_BIT  = 4;
    localparam int EXP_CKDET_BIT = 5;
    localparam int FMT_MUX_BIT   = 0;
    localparam int FMT_INV_BIT   = 1;
    localparam int FMT_SQ_BIT    = 2;
    localparam int FMT_RND_LO    = 4;
    localparam logic [7:0] MANT_RST    = 8'h00;
    localparam logic [7:0] EXP_RST     = 8'h00;
    localparam logic [7:0] FMT_RST     = 8'h80;
    localparam logic [7:0] EXP_RW_MASK = 8'h3F;
    localparam logic [1:0] MANT_LEAD   = 2'h1;
    localparam logic [3:0] BASE_TOP    = 4'h6;
    localparam logic [3:0] BASE_CODE7  = 4'h7;
    localparam int RND_10 = 10;
    localparam int RND_12 = 12;
    localparam int RND_14 = 14;
    localparam int RND_16 = 16;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// File: rtl/ogf_top.sv
// output gain, rounding and word formatting stage with ahb-lite registers
`timescale 1ns/1ps
// Summary of operation
// (R1) 8-bit gain mantissa register, fully read/write.
// (R2) 4-bit gain exponent in bits 0..3 of exponent register.
// (R3) gain is 2^(exponent-base) times (1 + mantissa/256).
// (R4) base is 6 for codes 0,1, one less per step, 0 at 7.
// (R5) unity gain puts a 12-bit input in the top 12 output bits.
// (R6) gains double buffered; without sync mode they apply right after exponent write.
// (R7) in sync mode buffered gains apply when gain sync strobe falls.
// (R8) only an exponent write starts a gain update.
// (R9) host writes mantissa first, then always the exponent.
// (R10) exponent bit 5 turns clock loss detect off, resets to zero.
// (R11) interleave bit puts I then Q on I port, strobe rate doubled.
// (R12) interleaved: Q port zero, in-phase marker high during I half.
// (R13) format bit 1 inverts the word strobe.
// (R14) default strobe pulses one cycle before each output word change.
// (R15) format bit 2 gives square-wave strobe rising mid output period.
// (R16) format bits 4..7 round to top 10, 12, 14 or 16 bits.
// (R17) host sets exactly one rounding bit.
// (R18) bits below the rounding width read zero.
// (R19) gain stage saturates on overflow, always.
// (R20) rounding adds half an lsb, saturates, samples two's complement.
module ogf_top
    import ogf_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic      [31:0]              hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    input  wire logic [DEC_W-1:0]         decimation_code,
    input  wire logic                     gain_sync_strobe_n,
    input  wire logic                     in_valid,
    input  wire logic signed [SAMP_W-1:0] in_i,
    input  wire logic signed [SAMP_W-1:0] in_q,
    output logic      [SAMP_W-1:0]        out_i,
    output logic      [SAMP_W-1:0]        out_q,
    output logic                          word_strobe,
    output logic                          in_phase_marker,
    output logic                          clock_loss_detect_off
);

    typedef struct packed {
        logic [7:0]        mant;
        logic [7:0]        expo;
        logic [7:0]        fmt;
        logic [7:0]        act_mant;
        logic [EXP_W-1:0]  act_exp;
        logic              gain_pend;
        logic              gs_s1;
        logic              gs_s2;
        logic              gs_s3;
        logic              wr_pend;
        logic [ADDR_W-1:0] wr_addr;
        logic [SAMP_W-1:0] hold_i;
        logic [SAMP_W-1:0] hold_q;
        logic              fresh;
        logic [CNT_W-1:0]  cnt;
        logic [CNT_W-1:0]  period;
        logic [SAMP_W-1:0] out_i;
        logic [SAMP_W-1:0] out_q;
        logic              ws;
        logic              marker;
        logic [31:0]       hrdata;
        logic              hready;
    } ogf_state_s;

    ogf_state_s st_ff;
    ogf_state_s nxt_st;

    // base shift from decimation code
    function automatic logic [EXP_W-1:0] ogf_base(input logic [DEC_W-1:0] code);
        if (code <= DEC_W'(1)) begin
            ogf_base = BASE_TOP; // R4
        end else begin
            ogf_base = BASE_CODE7 - EXP_W'(code); // R4
        end
    endfunction

    // gain, round and saturate one sample; result keeps 8 fraction bits before rounding
    function automatic logic [SAMP_W-1:0] ogf_scale(
        input logic signed [SAMP_W-1:0] x,
        input logic [7:0]               m,
        input logic [EXP_W-1:0]         s,
        input logic [EXP_W-1:0]         b,
        input logic [3:0]               rsel
    );
        logic signed [SAMP_W+9:0] prod;
        logic signed [FULL_W-1:0] v;
        logic signed [FULL_W-1:0] one;
        logic signed [FULL_W-1:0] lim;
        int                       n;
        int                       k;
        prod = x * $signed({MANT_LEAD, m}); // R3
        v    = (FULL_W'(prod) <<< s) >>> b; // R3 R5
        one  = FULL_W'(1);
        n    = rsel[0] ? RND_10 : rsel[1] ? RND_12 : rsel[2] ? RND_14 : RND_16; // R16
        k    = FRAC_W + SAMP_W - n;
        v    = (v + (one <<< (k - 1))) >>> k; // R20
        lim  = (one <<< (n - 1)) - one;
        if (v > lim) begin
            v = lim; // R19 R20
        end else if (v < -lim - one) begin
            v = -lim - one; // R19 R20
        end
        ogf_scale = SAMP_W'(v <<< (SAMP_W - n)); // R18
    endfunction

    logic              ahb_sel;
    logic              exp_wr;
    logic              mux_on;
    logic              gs_fall;
    logic [CNT_W-1:0]  half;
    logic [CNT_W-1:0]  seg;
    logic [CNT_W-1:0]  ph;
    logic              sq;
    logic              pulse;

    always_comb begin
        nxt_st  = st_ff;
        ahb_sel = hsel & hready & htrans[1];
        exp_wr  = 1'b0;
        // bus data phase: single word writes take effect at its end
        if (st_ff.wr_pend) begin
            case (st_ff.wr_addr)
                ADDR_MANT: begin
                    nxt_st.mant = hwdata[7:0]; // R1
                end
                ADDR_EXP: begin
                    nxt_st.expo = hwdata[7:0] & EXP_RW_MASK; // R2 R10
                    exp_wr      = 1'b1; // R8
                end
                ADDR_FMT: begin
                    nxt_st.fmt = hwdata[7:0];
                end
                default: begin
                end
            endcase
        end
        nxt_st.wr_pend = ahb_sel & hwrite;
        nxt_st.wr_addr = haddr[ADDR_W-1:0];
        nxt_st.hready  = 1'b1;
        nxt_st.hrdata  = 32'h0000_0000;
        // read from next values so a write just before is seen
        if (ahb_sel && !hwrite) begin
            case (haddr[ADDR_W-1:0])
                ADDR_MANT: nxt_st.hrdata = {24'h00_0000, nxt_st.mant};
                ADDR_EXP:  nxt_st.hrdata = {24'h00_0000, nxt_st.expo};
                ADDR_FMT:  nxt_st.hrdata = {24'h00_0000, nxt_st.fmt};
                default:   nxt_st.hrdata = 32'h0000_0000;
            endcase
        end

        // gain strobe synchroniser; edge seen on stages two and three
        nxt_st.gs_s1 = gain_sync_strobe_n;
        nxt_st.gs_s2 = st_ff.gs_s1;
        nxt_st.gs_s3 = st_ff.gs_s2;
        gs_fall      = st_ff.gs_s3 & ~st_ff.gs_s2;
        if (st_ff.gain_pend && gs_fall && st_ff.expo[EXP_SYNC_BIT]) begin
            nxt_st.act_mant  = st_ff.mant; // R7
            nxt_st.act_exp   = st_ff.expo[EXP_W-1:0]; // R7
            nxt_st.gain_pend = 1'b0;
        end
        if (exp_wr) begin
            if (!nxt_st.expo[EXP_SYNC_BIT]) begin
                nxt_st.act_mant  = nxt_st.mant; // R6
                nxt_st.act_exp   = nxt_st.expo[EXP_W-1:0]; // R6
                nxt_st.gain_pend = 1'b0;
            end else begin
                nxt_st.gain_pend = 1'b1; // R7
            end
        end
        if (!st_ff.expo[EXP_SYNC_BIT] && st_ff.gain_pend) begin
            nxt_st.act_mant  = st_ff.mant;
            nxt_st.act_exp   = st_ff.expo[EXP_W-1:0];
            nxt_st.gain_pend = 1'b0;
        end

        // sample capture and output period measurement
        mux_on = st_ff.fmt[FMT_MUX_BIT];
        if (in_valid) begin
            nxt_st.hold_i = ogf_scale(in_i, st_ff.act_mant, st_ff.act_exp,
                                      ogf_base(decimation_code), st_ff.fmt[7:FMT_RND_LO]);
            nxt_st.hold_q = ogf_scale(in_q, st_ff.act_mant, st_ff.act_exp,
                                      ogf_base(decimation_code), st_ff.fmt[7:FMT_RND_LO]);
            nxt_st.cnt    = '0;
            nxt_st.period = (&st_ff.cnt) ? st_ff.cnt : st_ff.cnt + CNT_W'(1);
        end else if (!(&st_ff.cnt)) begin
            nxt_st.cnt = st_ff.cnt + CNT_W'(1);
        end
        nxt_st.fresh = in_valid;
        half = st_ff.period >> 1;

        // word changes: I at end of fresh cycle, Q with it, or in interleave half a period later
        if (st_ff.fresh) begin
            nxt_st.out_i  = st_ff.hold_i;
            nxt_st.marker = mux_on; // R12
        end else if (mux_on && st_ff.cnt == half && half != '0) begin
            nxt_st.out_i  = st_ff.hold_q; // R11
            nxt_st.marker = 1'b0; // R12
        end
        if (mux_on) begin
            nxt_st.out_q = '0; // R12
        end else begin
            nxt_st.marker = 1'b0;
            if (st_ff.fresh) begin
                nxt_st.out_q = st_ff.hold_q; // R11
            end
        end

        // strobe: pulse the cycle before a change, or square wave
        pulse = in_valid | (mux_on & (nxt_st.cnt == half) & (half != '0)); // R11 R14
        seg   = mux_on ? half : st_ff.period;
        ph    = (mux_on && nxt_st.cnt >= half) ? nxt_st.cnt - half : nxt_st.cnt;
        sq    = (ph >= (seg >> 1)); // R15
        nxt_st.ws = (st_ff.fmt[FMT_SQ_BIT] ? sq : pulse) ^ st_ff.fmt[FMT_INV_BIT]; // R13
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_ff      <= '0;
            st_ff.mant <= MANT_RST;
            st_ff.expo <= EXP_RST; // R10
            st_ff.fmt  <= FMT_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hrdata                = st_ff.hrdata;
    assign hreadyout             = st_ff.hready;
    assign hresp                 = 1'b0;
    assign out_i                 = st_ff.out_i;
    assign out_q                 = st_ff.out_q;
    assign word_strobe           = st_ff.ws;
    assign in_phase_marker       = st_ff.marker;
    assign clock_loss_detect_off = st_ff.expo[EXP_CKDET_BIT]; // R10

    a_exp_write_apply: assert property (@(posedge sys_clk) disable iff (rst) // R6
        (st_ff.wr_pend && st_ff.wr_addr == ADDR_EXP && !hwdata[EXP_SYNC_BIT])
        |=> (st_ff.act_exp == $past(hwdata[EXP_W-1:0]) && st_ff.act_mant == st_ff.mant))
        else $error("gain not applied after exponent write");

    a_sync_gain_hold: assert property (@(posedge sys_clk) disable iff (rst) // R7
        (st_ff.expo[EXP_SYNC_BIT] && !(st_ff.gs_s3 && !st_ff.gs_s2) && st_ff.gain_pend
         && !(st_ff.wr_pend && st_ff.wr_addr == ADDR_EXP))
        |=> $stable(st_ff.act_exp) && $stable(st_ff.act_mant))
        else $error("sync gain changed without strobe");

    a_mant_no_update: assert property (@(posedge sys_clk) disable iff (rst) // R8
        (st_ff.wr_pend && st_ff.wr_addr == ADDR_MANT && !st_ff.gain_pend)
        |=> $stable(st_ff.act_mant))
        else $error("mantissa write alone changed gain");

    a_ckdet_follow: assert property (@(posedge sys_clk) disable iff (rst) // R10
        (st_ff.wr_pend && st_ff.wr_addr == ADDR_EXP)
        |=> clock_loss_detect_off == $past(hwdata[EXP_CKDET_BIT]))
        else $error("clock loss detect bit wrong");

    a_q_zero_mux: assert property (@(posedge sys_clk) disable iff (rst) // R12
        $past(st_ff.fmt[FMT_MUX_BIT]) |-> out_q == '0
            && (!in_phase_marker || out_i == $past(st_ff.hold_i, 1) || $stable(out_i)))
        else $error("q port not zero in interleave");

    a_ws_invert: assert property (@(posedge sys_clk) disable iff (rst) // R13
        (in_valid && !st_ff.fmt[FMT_SQ_BIT]) |=> word_strobe == !$past(st_ff.fmt[FMT_INV_BIT]))
        else $error("strobe polarity wrong");

    a_ws_before_word: assert property (@(posedge sys_clk) disable iff (rst) // R14
        (in_valid && st_ff.fmt[2:1] == 2'h0) |=> word_strobe ##1 out_i == $past(st_ff.hold_i))
        else $error("strobe pulse not one cycle before word");

    a_low_bits_zero: assert property (@(posedge sys_clk) disable iff (rst) // R18
        (st_ff.fresh && st_ff.fmt[7:FMT_RND_LO] == 4'h1) |=> out_i[5:0] == 6'h00)
        else $error("bits below rounding width not zero");

endmodule

// File: tb/ogf_sink.sv
// downstream capture model for the output gain and format stage
`timescale 1ns/1ps
module ogf_sink
    import ogf_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              word_strobe,
    input  wire logic              strobe_invert,
    input  wire logic [SAMP_W-1:0] out_i,
    input  wire logic [SAMP_W-1:0] out_q,
    output logic      [SAMP_W-1:0] cap_i,
    output logic      [SAMP_W-1:0] cap_q
);
    logic seen_d;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seen_d <= 1'b0;
            cap_i  <= '0;
            cap_q  <= '0;
        end else begin
            seen_d <= word_strobe ^ strobe_invert;
            // take the word a cycle after the strobe, once it has changed
            if (seen_d) begin
                cap_i <= out_i;
                cap_q <= out_q;
            end
        end
    end
endmodule

// File: tb/test_output_gain_and_format.sv
// self-checking testbench for the output gain and format stage
`timescale 1ns/1ps
module test_output_gain_and_format
    import ogf_pkg::*;
;
    logic               sys_clk = 1'b0;
    logic               rst = 1'b1;
    logic               hsel = 1'b0;
    logic               hwrite = 1'b0;
    logic               hreadyout, hresp, word_strobe, in_phase_marker, clock_loss_detect_off;
    logic [31:0]        haddr = '0;
    logic [31:0]        hwdata = '0;
    logic [31:0]        hrdata;
    logic [1:0]         htrans = 2'h0;
    logic [DEC_W-1:0]   dec = '0;
    logic               gain_sync_strobe_n = 1'b1;
    logic               in_valid = 1'b0;
    logic signed [15:0] in_i = '0;
    logic signed [15:0] in_q = '0;
    logic [15:0]        out_i, out_q, cap_i, cap_q;
    int                 n_fail = 0;
    int                 checks = 0;
    int                 cyc = 0;

    ogf_top DUT (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .decimation_code(dec),
        .gain_sync_strobe_n(gain_sync_strobe_n), .in_valid(in_valid), .in_i(in_i),
        .in_q(in_q), .out_i(out_i), .out_q(out_q), .word_strobe(word_strobe),
        .in_phase_marker(in_phase_marker), .clock_loss_detect_off(clock_loss_detect_off));
    ogf_sink sink (.sys_clk(sys_clk), .rst(rst), .word_strobe(word_strobe),
        .strobe_invert(1'b0), .out_i(out_i), .out_q(out_q), .cap_i(cap_i), .cap_q(cap_q));

    always #10 sys_clk = ~sys_clk;

    task automatic wrap_up;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                       output logic [31:0] r);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= 32'(a);
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= 32'(d);
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, r);
        chk(nm, r, exp);
    endtask

    // mantissa always first, exponent always rewritten
    task automatic set_gain(input logic [7:0] m, input logic [7:0] e);
        wr(ADDR_MANT, m);
        wr(ADDR_EXP, e);
    endtask

    task automatic pulse(input logic [15:0] i, input logic [15:0] q);
        @(posedge sys_clk);
        in_i     <= i;
        in_q     <= q;
        in_valid <= 1'b1;
        @(posedge sys_clk);
        in_valid <= 1'b0;
    endtask

    task automatic send(input logic [15:0] i, q, ei, eq, input logic inv);
        logic [15:0] prev;
        prev = out_i;
        pulse(i, q);
        #1 chk("strobe active", 32'(word_strobe), 32'(!inv));
        chk("out_i early", 32'(out_i), 32'(prev));
        @(posedge sys_clk);
        #1 chk("out_i", 32'(out_i), 32'(ei));
        chk("out_q", 32'(out_q), 32'(eq));
        chk("strobe idle", 32'(word_strobe), 32'(inv));
        repeat (4) @(posedge sys_clk);
    endtask

    function automatic logic [15:0] rnd(input logic [15:0] x, input int w);
        int s;
        s = 16 - w;
        if (w == 16)
            return x;
        return (x + 16'(1 << (s - 1))) & ~16'((1 << s) - 1);
    endfunction

    task automatic t_regs;
        rd("mant rst", ADDR_MANT, 32'h00);
        rd("exp rst", ADDR_EXP, 32'h00);
        rd("fmt rst", ADDR_FMT, 32'h80);
        wr(ADDR_MANT, 8'hA5);
        rd("mant rw", ADDR_MANT, 32'hA5);
        wr(ADDR_EXP, 8'hFF);
        rd("exp rw", ADDR_EXP, 32'h3F);
        chk("ckdet on", 32'(clock_loss_detect_off), 32'h1);
        rd("unmapped", 12'h040, 32'h00);
        chk("hresp", 32'(hresp), 32'h0);
        wr(ADDR_EXP, 8'h06);
        #1 chk("ckdet off", 32'(clock_loss_detect_off), 32'h0);
    endtask

    task automatic t_gain;
        for (int c = 0; c < 8; c++) begin
            dec <= 3'(c);
            set_gain(8'h00, (c < 2) ? 8'h06 : 8'(7 - c));
            send(16'h1230, 16'hEDD0, 16'h1230, 16'hEDD0, 1'b0);
        end
        dec <= 3'h0;
        set_gain(8'h80, 8'h07);
        send(16'h1230, 16'h0100, 16'h3690, 16'h0300, 1'b0);
        wr(ADDR_MANT, 8'h00);
        send(16'h1230, 16'h0100, 16'h3690, 16'h0300, 1'b0);
        set_gain(8'h00, 8'h0F);
        send(16'h1230, 16'hEDD0, 16'h7FFF, 16'h8000, 1'b0);
        chk("sink word", 32'(cap_q), 32'h8000);
        chk("sink word i", 32'(cap_i), 32'h7FFF);
    endtask

    task automatic t_sync;
        set_gain(8'h00, 8'h17);
        // old saturating gain must still hold until the strobe
        send(16'h1230, 16'h0100, 16'h7FFF, 16'h7FFF, 1'b0);
        gain_sync_strobe_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        gain_sync_strobe_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        send(16'h1230, 16'h0100, 16'h2460, 16'h0200, 1'b0);
        set_gain(8'h00, 8'h06);
    endtask

    task automatic t_round;
        for (int b = 4; b < 8; b++) begin
            wr(ADDR_FMT, 8'(1 << b));
            send(16'h1237, 16'hEDC9, rnd(16'h1237, 2 * b + 2), rnd(16'hEDC9, 2 * b + 2),
                 1'b0);
        end
        wr(ADDR_FMT, 8'h82);
        send(16'h1237, 16'h0011, 16'h1237, 16'h0011, 1'b1);
    endtask

    // period of 8 between samples, so q half lands mid period
    task automatic t_mux;
        wr(ADDR_FMT, 8'h81);
        pulse(16'h1000, 16'h2000);
        repeat (6) @(posedge sys_clk);
        pulse(16'h1110, 16'h2220);
        @(posedge sys_clk);
        #1 chk("mux i", 32'(out_i), 32'h1110);
        chk("mux q port", 32'(out_q), 32'h0);
        chk("marker i", 32'(in_phase_marker), 32'h1);
        repeat (3) @(posedge sys_clk);
        #1 chk("mux strobe", 32'(word_strobe), 32'h1);
        @(posedge sys_clk);
        #1 chk("mux q", 32'(out_i), 32'h2220);
        chk("marker q", 32'(in_phase_marker), 32'h0);
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic t_square;
        wr(ADDR_FMT, 8'h84);
        pulse(16'h0100, 16'h0200);
        repeat (6) @(posedge sys_clk);
        pulse(16'h0300, 16'h0400);
        @(posedge sys_clk);
        #1 chk("square low", 32'(word_strobe), 32'h0);
        repeat (5) @(posedge sys_clk);
        #1 chk("square high", 32'(word_strobe), 32'h1);
        wr(ADDR_FMT, 8'h80);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_gain();
        t_sync();
        t_round();
        t_mux();
        t_square();
        wrap_up();
    end
endmodule
